// ### rtl/dcw_irq_ctrl.sv
// dcw_irq_ctrl: interrupt, chain and wait/request logic
// assumes: apb on clk; strobes and modem pins async; data path
// event inputs synchronous to clk
// Operation
// - channel B vector read carries three status bits
// - six sources, each pending, in-service, enable
// - request needs source enable and global enable
// - source enables are write only
// - unblocked pending, global enable and chain in high pull request low
// - disabled source never sets its pending flag
// - pending set two or three strobe edges later
// - all pending flags readable through channel A
// - in-service blocks lower sources and chain out
// - ack sets in-service of top pending
// - channel A over B; rx, tx, ext
// - tx interrupt when loaded buffer goes empty
// - receive modes: first, all, special only
// - special: overrun, optional parity error
// - first mode: specials after first character
// - ext status on pin edges, underrun, zero, break
// - wait/request function chosen in transfer mode
// - request means ready; wait means not ready
// - terminal ready pin usable as second request
// - vector and master control shared, rest per channel
// - channel select from bit 0 or 5
// - ack drives vector, sets in-service
// - wait/request starts in open-drain wait mode
//
// The implementer's own choices: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
module dcw_irq_ctrl
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [dcw_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // host strobes and daisy chain
    input wire logic address_strobe_n,
    input wire logic data_strobe_n,
    input wire logic irq_acknowledge_in_n,
    input wire logic chain_enable_in,
    output logic chain_enable_out,
    // interrupt request and vector
    output logic irq_req_n_o,
    output logic irq_req_oe,
    output logic [7:0] ad_o,
    output logic ad_oe,
    // modem pins, index 0 channel A
    input wire logic [1:0] cts_n,
    input wire logic [1:0] carrier_detect_in_n,
    input wire logic [1:0] ring_indicator_in_n,
    // data path events
    input wire logic [1:0] rx_char_avail,
    input wire logic [1:0] rx_char,
    input wire logic [1:0] rx_overrun,
    input wire logic [1:0] rx_parity_err,
    input wire logic [1:0] tx_written,
    input wire logic [1:0] tx_empty,
    input wire logic [1:0] tx_underrun,
    input wire logic [1:0] baud_zero,
    input wire logic [1:0] break_det,
    // wait/request pins
    output logic [1:0] wreq_n_o,
    output logic [1:0] wreq_oe,
    output logic [1:0] dtr_req_n
);

    localparam int NP = 10;

    logic [NP-1:0] pin_raw;
    logic [NP-1:0] sync1_q;
    logic [NP-1:0] sync2_q;
    logic [NP-1:0] prev_q;
    logic as_rise;
    logic ds_fall;
    logic ds_rise;
    logic ack_lvl;
    logic chain_in;
    logic [1:0] ext_edge;
    logic [7:0] mode_q [2];
    logic [7:0] misc_q [2];
    logic [7:0] vec_q;
    logic [7:0] mic_q;
    logic shl_q;
    logic [1:0] rx_armed_q;
    logic [1:0] tx_loaded_q;
    logic [1:0] spc;
    logic [1:0] spc_seen_q;
    logic [5:0] en;
    logic [5:0] cond;
    logic [5:0] seen_q;
    logic [5:0] stage_q;
    logic [5:0] pend_q;
    logic [5:0] pend_clr;
    logic [5:0] ius_q;
    logic [5:0] ius_clr;
    logic [5:0] req;
    logic [5:0] top;
    logic [2:0] code;
    logic [7:0] vec_mod;
    logic [1:0] ready;
    dcw_pkg::dcw_ack_st_t ack_q;
    logic access;
    logic hit;
    logic chan;
    logic [3:0] rnum;
    logic stall;
    logic wr_fire;
    logic cmd_fire;
    logic [2:0] cmd;
    logic [7:0] rdata;

    // lowest index set bit, one-hot
    function automatic logic [5:0] first_set(input logic [5:0] v);
        logic [5:0] r;
        r = 6'h00;
        for (int i = 5; i >= 0; i--)
        begin
            if (v[i])
            begin
                r = 6'h00;
                r[i] = 1'b1;
            end
        end
        return r;
    endfunction : first_set

    // two-flop sync plus history stage
    assign pin_raw = {ring_indicator_in_n, carrier_detect_in_n, cts_n, chain_enable_in,
                      irq_acknowledge_in_n, data_strobe_n, address_strobe_n};

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sync1_q <= '1;
            sync2_q <= '1;
            prev_q <= '1;
        end
        else
        begin
            sync1_q <= pin_raw;
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
        end
    end

    // strobe edges and levels
    assign as_rise = sync2_q[0] & ~prev_q[0];
    assign ds_fall = ~sync2_q[1] & prev_q[1];
    assign ds_rise = sync2_q[1] & ~prev_q[1];
    assign ack_lvl = ~sync2_q[2];
    assign chain_in = sync2_q[3];

    // apb decode: word index is the host address byte
    assign access = psel & penable;
    assign hit = (paddr[dcw_pkg::ADDR_W-1:10] == '0);
    assign chan = shl_q ? ~paddr[7] : ~paddr[2];
    assign rnum = paddr[6:3];
    assign wr_fire = access & pready & pwrite & hit;
    assign cmd_fire = wr_fire & (rnum == dcw_pkg::REG_CMD);
    assign cmd = pwdata[dcw_pkg::CMD_MSB:dcw_pkg::CMD_LSB];

    // readiness and source enables
    always_comb
    begin
        for (int c = 0; c < 2; c++)
        begin
            ready[c] = mode_q[c][dcw_pkg::MODE_WR_DIR] ? rx_char_avail[c] : tx_empty[c];
            en[3*c+dcw_pkg::SRC_RX] =
                mode_q[c][dcw_pkg::MODE_RX_MSB:dcw_pkg::MODE_RX_LSB] != dcw_pkg::RX_OFF;
            en[3*c+dcw_pkg::SRC_TX] = mode_q[c][dcw_pkg::MODE_TX_IE];
            en[3*c+dcw_pkg::SRC_EXT] = mode_q[c][dcw_pkg::MODE_EXT_IE];
        end
    end

    // wait mode stalls data access until ready
    assign stall = access & hit & ~pready & (rnum == dcw_pkg::REG_DATA)
        & mode_q[chan][dcw_pkg::MODE_WR_EN] & ~mode_q[chan][dcw_pkg::MODE_WR_FN]
        & ~ready[chan];

    // interrupt conditions per source
    always_comb
    begin
        cond = 6'h00;
        spc = 2'h0;
        ext_edge = 2'h0;
        for (int c = 0; c < 2; c++)
        begin
            spc[c] = rx_overrun[c] | (rx_parity_err[c] & mode_q[c][dcw_pkg::MODE_PAR_SPC]);
            unique case (mode_q[c][dcw_pkg::MODE_RX_MSB:dcw_pkg::MODE_RX_LSB])
                dcw_pkg::RX_OFF: cond[3*c] = 1'b0;
                dcw_pkg::RX_FIRST: cond[3*c] = (rx_char[c] & rx_armed_q[c])
                    | (spc[c] & ~rx_armed_q[c]);
                dcw_pkg::RX_ALL: cond[3*c] = rx_char[c] | spc[c];
                dcw_pkg::RX_SPC: cond[3*c] = spc[c];
            endcase
            cond[3*c+1] = tx_loaded_q[c] & tx_empty[c];
            ext_edge[c] = (sync2_q[4+c] ^ prev_q[4+c]) | (sync2_q[6+c] ^ prev_q[6+c])
                | (sync2_q[8+c] ^ prev_q[8+c]);
            cond[3*c+2] = ext_edge[c] | tx_underrun[c] | baud_zero[c] | break_det[c];
        end
    end

    // first character arming, tx loaded flags
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rx_armed_q <= 2'h3;
            tx_loaded_q <= 2'h0;
        end
        else
        begin
            for (int c = 0; c < 2; c++)
            begin
                if (wr_fire && rnum == dcw_pkg::REG_MODE && int'(chan) == c)
                    rx_armed_q[c] <= 1'b1;
                else if (rx_char[c] && en[3*c]
                         && mode_q[c][dcw_pkg::MODE_RX_MSB:dcw_pkg::MODE_RX_LSB]
                            == dcw_pkg::RX_FIRST)
                    rx_armed_q[c] <= 1'b0;
                if (tx_written[c])
                    tx_loaded_q[c] <= 1'b1;
                else if (tx_empty[c])
                    tx_loaded_q[c] <= 1'b0;
            end
        end
    end

    // conditions ride two strobe edges to pending
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            seen_q <= 6'h00;
            stage_q <= 6'h00;
        end
        else if (as_rise)
        begin
            stage_q <= seen_q & en;
            seen_q <= cond & en;
        end
        else
        begin
            seen_q <= seen_q | (cond & en);
        end
    end

    // pending clears
    always_comb
    begin
        pend_clr = 6'h00;
        if (cmd_fire)
        begin
            pend_clr[3*chan+dcw_pkg::SRC_EXT] = cmd == dcw_pkg::CMD_RST_EXT;
            pend_clr[3*chan+dcw_pkg::SRC_TX] = cmd == dcw_pkg::CMD_RST_TX;
            pend_clr[3*chan+dcw_pkg::SRC_RX] = cmd == dcw_pkg::CMD_RST_RX;
        end
    end

    // pending flags, set wins over clear
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            pend_q <= 6'h00;
        else
            pend_q <= (pend_q & ~pend_clr) | (as_rise ? (stage_q & en) : 6'h00);
    end

    // special status for vector
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            spc_seen_q <= 2'h0;
        else
        begin
            for (int c = 0; c < 2; c++)
            begin
                if (spc[c] && cond[3*c] && en[3*c])
                    spc_seen_q[c] <= 1'b1;
                else if (pend_clr[3*c])
                    spc_seen_q[c] <= 1'b0;
            end
        end
    end

    // internal chain: in-service blocks all below
    always_comb
    begin
        logic blk;
        blk = 1'b0;
        req = 6'h00;
        for (int i = 0; i < dcw_pkg::NSRC; i++)
        begin
            blk = blk | ius_q[i];
            req[i] = pend_q[i] & mic_q[dcw_pkg::MIC_MIE] & ~blk;
        end
    end

    assign top = first_set(req);
    assign ius_clr = (cmd_fire && cmd == dcw_pkg::CMD_RST_IUS) ? first_set(ius_q) : 6'h00;

    // status of top source
    always_comb
    begin
        code = dcw_pkg::ST_NONE;
        if (top[0])
            code = spc_seen_q[0] ? dcw_pkg::ST_A_SPC : dcw_pkg::ST_A_RX;
        else if (top[1])
            code = dcw_pkg::ST_A_TX;
        else if (top[2])
            code = dcw_pkg::ST_A_EXT;
        else if (top[3])
            code = spc_seen_q[1] ? dcw_pkg::ST_B_SPC : dcw_pkg::ST_B_RX;
        else if (top[4])
            code = dcw_pkg::ST_B_TX;
        else if (top[5])
            code = dcw_pkg::ST_B_EXT;
    end

    assign vec_mod = {vec_q[7:4], code, vec_q[0]};

    // acknowledge cycle
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ack_q <= dcw_pkg::ACK_IDLE;
            ius_q <= 6'h00;
            ad_o <= 8'h00;
            ad_oe <= 1'b0;
        end
        else
        begin
            ius_q <= ius_q & ~ius_clr;
            unique case (ack_q)
                dcw_pkg::ACK_IDLE:
                begin
                    if (as_rise && ack_lvl)
                        ack_q <= dcw_pkg::ACK_WAIT_DS;
                end
                dcw_pkg::ACK_WAIT_DS:
                begin
                    if (as_rise && !ack_lvl)
                        ack_q <= dcw_pkg::ACK_IDLE;
                    else if (ds_fall)
                    begin
                        if (chain_in && req != 6'h00)
                        begin
                            ius_q <= (ius_q & ~ius_clr) | top;
                            ad_o <= mic_q[dcw_pkg::MIC_VIS] ? vec_mod : vec_q;
                            ad_oe <= 1'b1;
                            ack_q <= dcw_pkg::ACK_DRIVE;
                        end
                        else
                            ack_q <= dcw_pkg::ACK_IDLE;
                    end
                end
                dcw_pkg::ACK_DRIVE:
                begin
                    if (ds_rise)
                    begin
                        ad_oe <= 1'b0;
                        ack_q <= dcw_pkg::ACK_IDLE;
                    end
                end
            endcase
        end
    end

    // interrupt request and chain out
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            irq_req_n_o <= 1'b0;
            irq_req_oe <= 1'b0;
            chain_enable_out <= 1'b0;
        end
        else
        begin
            irq_req_n_o <= 1'b0;
            irq_req_oe <= chain_in & (req != 6'h00);
            chain_enable_out <= chain_in & (ius_q == 6'h00) & (pend_q == 6'h00);
        end
    end

    // writable registers
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            mode_q[0] <= dcw_pkg::MODE_RST;
            mode_q[1] <= dcw_pkg::MODE_RST;
            misc_q[0] <= dcw_pkg::MISC_RST;
            misc_q[1] <= dcw_pkg::MISC_RST;
            vec_q <= dcw_pkg::VEC_RST;
            mic_q <= dcw_pkg::MIC_RST;
            shl_q <= 1'b0;
        end
        else if (wr_fire)
        begin
            case (rnum)
                dcw_pkg::REG_MODE: mode_q[chan] <= pwdata[7:0];
                dcw_pkg::REG_MISC: misc_q[chan] <= pwdata[7:0];
                dcw_pkg::REG_VEC: vec_q <= pwdata[7:0];
                dcw_pkg::REG_MIC: mic_q <= pwdata[7:0];
                dcw_pkg::REG_CMD:
                begin
                    if (chan && cmd == dcw_pkg::CMD_SHL)
                        shl_q <= 1'b1;
                    else if (chan && cmd == dcw_pkg::CMD_SHR)
                        shl_q <= 1'b0;
                end
                default: shl_q <= shl_q;
            endcase
        end
    end

    // read data; source enables never come back
    always_comb
    begin
        rdata = 8'h00;
        if (hit)
        begin
            case (rnum)
                dcw_pkg::REG_CMD: rdata = {2'h0, ~sync2_q[4+chan], ~sync2_q[8+chan],
                    ~sync2_q[6+chan], tx_empty[chan], 1'b0, rx_char_avail[chan]};
                dcw_pkg::REG_VEC: rdata = chan ? vec_mod : vec_q;
                dcw_pkg::REG_PEND: rdata = chan ? 8'h00 : {2'h0, pend_q};
                default: rdata = 8'h00;
            endcase
        end
    end

    // apb answer, stall extends
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= access & ~pready & ~stall;
            if (access && !pready && !stall)
            begin
                prdata <= pwrite ? 32'h0000_0000 : {24'h00_0000, rdata};
                pslverr <= ~hit;
            end
        end
    end

    // wait/request pins
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wreq_n_o <= 2'h0;
            wreq_oe <= 2'h0;
            dtr_req_n <= 2'h3;
        end
        else
        begin
            for (int c = 0; c < 2; c++)
            begin
                if (mode_q[c][dcw_pkg::MODE_WR_FN])
                begin
                    wreq_oe[c] <= 1'b1;
                    wreq_n_o[c] <= ~(mode_q[c][dcw_pkg::MODE_WR_EN] & ready[c]);
                end
                else
                begin
                    wreq_oe[c] <= stall & (int'(chan) == c);
                    wreq_n_o[c] <= 1'b0;
                end
                dtr_req_n[c] <= misc_q[c][dcw_pkg::MISC_REQ_FN] ? ~tx_empty[c]
                    : ~misc_q[c][dcw_pkg::MISC_DTR];
            end
        end
    end

endmodule : dcw_irq_ctrl

// ### rtl/dcw_pkg.sv
// dcw_pkg: constants and types of the interrupt block
// assumes: compiled before rtl/dcw_irq_ctrl.sv
package dcw_pkg;

    // apb address width
    localparam int ADDR_W = 12;

    // source numbering, channel A first
    localparam int NSRC = 6;
    localparam int SRC_RX = 0;
    localparam int SRC_TX = 1;
    localparam int SRC_EXT = 2;

    // register numbers
    localparam logic [3:0] REG_CMD = 4'h0;
    localparam logic [3:0] REG_MODE = 4'h1;
    localparam logic [3:0] REG_VEC = 4'h2;
    localparam logic [3:0] REG_PEND = 4'h3;
    localparam logic [3:0] REG_DATA = 4'h8;
    localparam logic [3:0] REG_MIC = 4'h9;
    localparam logic [3:0] REG_MISC = 4'hE;

    // channel command field
    localparam int CMD_LSB = 3;
    localparam int CMD_MSB = 5;
    localparam logic [2:0] CMD_RST_EXT = 3'h1;
    localparam logic [2:0] CMD_RST_TX = 3'h2;
    localparam logic [2:0] CMD_RST_RX = 3'h3;
    localparam logic [2:0] CMD_RST_IUS = 3'h4;
    localparam logic [2:0] CMD_SHL = 3'h5;
    localparam logic [2:0] CMD_SHR = 3'h6;

    // transfer mode register fields
    localparam int MODE_EXT_IE = 0;
    localparam int MODE_TX_IE = 1;
    localparam int MODE_PAR_SPC = 2;
    localparam int MODE_RX_LSB = 3;
    localparam int MODE_RX_MSB = 4;
    localparam int MODE_WR_DIR = 5;
    localparam int MODE_WR_FN = 6;
    localparam int MODE_WR_EN = 7;
    localparam logic [1:0] RX_OFF = 2'h0;
    localparam logic [1:0] RX_FIRST = 2'h1;
    localparam logic [1:0] RX_ALL = 2'h2;
    localparam logic [1:0] RX_SPC = 2'h3;

    // master control and misc fields
    localparam int MIC_VIS = 0;
    localparam int MIC_MIE = 3;
    localparam int MISC_DTR = 0;
    localparam int MISC_REQ_FN = 2;

    // values after reset
    localparam logic [7:0] VEC_RST = 8'h00;
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [7:0] MIC_RST = 8'h00;
    localparam logic [7:0] MISC_RST = 8'h00;

    // vector status codes
    localparam logic [2:0] ST_B_TX = 3'h0;
    localparam logic [2:0] ST_B_EXT = 3'h1;
    localparam logic [2:0] ST_B_RX = 3'h2;
    localparam logic [2:0] ST_B_SPC = 3'h3;
    localparam logic [2:0] ST_A_TX = 3'h4;
    localparam logic [2:0] ST_A_EXT = 3'h5;
    localparam logic [2:0] ST_A_RX = 3'h6;
    localparam logic [2:0] ST_A_SPC = 3'h7;
    localparam logic [2:0] ST_NONE = 3'h3;

    // acknowledge cycle states
    typedef enum logic [1:0] {ACK_IDLE, ACK_WAIT_DS, ACK_DRIVE} dcw_ack_st_t;

endpackage : dcw_pkg

// ### dv/dcw_irq_ctrl_assertions.sv
// checker: chain, request and vector
// assumes: bound to dcw_irq_ctrl
`timescale 1ns/10ps
module dcw_irq_chk
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // watched ports
    input wire logic data_strobe_n,
    input wire logic irq_acknowledge_in_n,
    input wire logic chain_enable_in,
    input wire logic chain_enable_out,
    input wire logic irq_req_n_o,
    input wire logic irq_req_oe,
    input wire logic [7:0] ad_o,
    input wire logic ad_oe,
    input wire logic pready,
    input wire logic pslverr
);
    // one clock domain
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // request and chain
    a_req_pulls_low: assert property (irq_req_n_o == 1'h0)
        else $error("request pin high");
    a_req_chain_low: assert property ($rose(irq_req_oe) |-> !chain_enable_out)
        else $error("chain out high");
    a_chain_blocks_req: assert property (!chain_enable_in [*6] |-> !irq_req_oe)
        else $error("request, chain low");
    a_chain_passes_low: assert property (!chain_enable_in [*4] |-> !chain_enable_out)
        else $error("chain low not passed");
    // acknowledge and vector
    a_ack_after_ds: assert property ($rose(ad_oe) |->
        !$past(data_strobe_n, 2) && !irq_acknowledge_in_n)
        else $error("vector outside ack");
    a_ack_needs_chain: assert property ($rose(ad_oe) |-> $past(chain_enable_in, 3))
        else $error("vector with chain low");
    a_vector_holds: assert property (ad_oe && !data_strobe_n |=> ad_oe && $stable(ad_o))
        else $error("vector changed");
    a_ack_in_service: assert property ($rose(ad_oe) |-> ##[0:4] !chain_enable_out)
        else $error("chain out after ack");
    // main scenarios
    c_ack: cover property ($rose(ad_oe));
    c_req: cover property ($rose(irq_req_oe));
    c_err: cover property (pready && pslverr);
endmodule : dcw_irq_chk

bind dcw_irq_ctrl dcw_irq_chk u_chk (.clk, .rst, .data_strobe_n, .irq_acknowledge_in_n,
    .chain_enable_in, .chain_enable_out, .irq_req_n_o, .irq_req_oe, .ad_o, .ad_oe, .pready,
    .pslverr);

// ### dv/dcw_host_model.sv
// host model: cpu strobes and acknowledge
// assumes: strobe levels held four clocks
`timescale 1ns/10ps
module dcw_host_model
(
    // clock
    input wire logic clk,
    // strobes, active low
    output logic address_strobe_n = 1'h1,
    output logic data_strobe_n = 1'h1,
    output logic irq_acknowledge_in_n = 1'h1
);
    // one address strobe cycle
    task as_cyc;
        @(posedge clk);
        address_strobe_n <= 1'h0;
        repeat (4) @(posedge clk);
        address_strobe_n <= 1'h1;
        repeat (4) @(posedge clk);
    endtask : as_cyc
    // acknowledge: strobe with ack low, then data strobe
    task ack_go;
        irq_acknowledge_in_n <= 1'h0;
        as_cyc();
        data_strobe_n <= 1'h0;
        repeat (6) @(posedge clk);
    endtask : ack_go
    // end of acknowledge
    task ack_done;
        data_strobe_n <= 1'h1;
        repeat (6) @(posedge clk);
        irq_acknowledge_in_n <= 1'h1;
        @(posedge clk);
    endtask : ack_done
endmodule : dcw_host_model

// ### dv/testbench.sv
// testbench: apb and strobe sequences
// assumes: host model drives strobes
`timescale 1ns/10ps
module testbench;
    // design signals
    logic clk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic pready, pslverr, perr, chain_enable_out, irq_req_n_o, irq_req_oe, ad_oe;
    logic chain_enable_in = 1'h1, shl = 1'h0;
    logic address_strobe_n, data_strobe_n, irq_acknowledge_in_n;
    logic [7:0] ad_o;
    logic [1:0] cts_n = 2'h3, carrier_detect_in_n = 2'h3, ring_indicator_in_n = 2'h3;
    logic [1:0] rx_char_avail = 2'h0, rx_char = 2'h0, rx_overrun = 2'h0, rx_parity_err = 2'h0;
    logic [1:0] tx_written = 2'h0, tx_empty = 2'h0, tx_underrun = 2'h0, baud_zero = 2'h0;
    logic [1:0] break_det = 2'h0, wreq_n_o, wreq_oe, dtr_req_n;
    int fail_count = 0, comparisons = 0, cyc = 0;
    // clock
    always #5 clk = ~clk;
    // design, host
    dcw_irq_ctrl dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .address_strobe_n, .data_strobe_n, .irq_acknowledge_in_n, .chain_enable_in,
        .chain_enable_out, .irq_req_n_o, .irq_req_oe, .ad_o, .ad_oe, .cts_n,
        .carrier_detect_in_n, .ring_indicator_in_n, .rx_char_avail, .rx_char, .rx_overrun,
        .rx_parity_err, .tx_written, .tx_empty, .tx_underrun, .baud_zero, .break_det,
        .wreq_n_o, .wreq_oe, .dtr_req_n);
    dcw_host_model host (.clk, .address_strobe_n, .data_strobe_n, .irq_acknowledge_in_n);
    // verdict
    task final_report;
        if (fail_count == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : final_report
    // compare
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e)
        begin
            $display("mismatch %s expected %h seen %h", n, e, g);
            fail_count++;
        end
    endtask : chk
    // register address
    function automatic logic [11:0] adr(input logic b, input logic [3:0] r);
        return shl ? {4'h0, ~b, r, 1'h0, 2'h0} : {5'h00, r, ~b, 2'h0};
    endfunction : adr
    // one apb transfer
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        @(posedge clk);
        while (pready !== 1'h1)
            @(posedge clk);
        rdat = prdata;
        perr = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge clk);
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'h1, a, {24'h0, d});
    endtask : wr
    task automatic rdc(input logic [11:0] a, input logic [7:0] e);
        apb(1'h0, a, 32'h0);
        chk("prdata", {24'h0, e}, rdat);
    endtask : rdc
    // strobe cycles then pending read
    task automatic pend(input int n, input logic [7:0] e);
        repeat (n) host.as_cyc();
        repeat (4) @(posedge clk);
        rdc(adr(1'h0, dcw_pkg::REG_PEND), e);
    endtask : pend
    // receive event under a mode
    task automatic rxs(input logic [7:0] m, input logic ovr, input logic [7:0] e);
        if (m != 8'h00)
            wr(adr(1'h0, dcw_pkg::REG_MODE), m);
        rx_char[0] <= ~ovr;
        rx_overrun[0] <= ovr;
        @(posedge clk);
        rx_char <= 2'h0;
        rx_overrun <= 2'h0;
        pend(2, e);
        wr(adr(1'h0, dcw_pkg::REG_CMD), 8'h18);
    endtask : rxs
    // hang limit
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            fail_count++;
            final_report();
        end
    end
    // main sequence
    initial
    begin
        repeat (4) @(posedge clk);
        rst <= 1'h0;
        chk("chain_out", 1'h0, chain_enable_out);
        chk("wreq_oe", 2'h0, wreq_oe);
        chk("dtr", 2'h3, dtr_req_n);
        apb(1'h0, 12'h400, 32'h0);
        chk("pslverr", 1'h1, perr);
        chk("chain_out", 1'h1, chain_enable_out);
        wr(adr(1'h1, dcw_pkg::REG_VEC), 8'hF0);
        rdc(adr(1'h0, dcw_pkg::REG_VEC), 8'hF0);
        rdc(adr(1'h1, dcw_pkg::REG_VEC), 8'hF6);
        wr(adr(1'h0, dcw_pkg::REG_MODE), 8'h02);
        rdc(adr(1'h0, dcw_pkg::REG_MODE), 8'h00);
        tx_written <= 2'h3;
        @(posedge clk);
        tx_written <= 2'h0;
        tx_empty <= 2'h3;
        pend(2, 8'h02);
        chk("irq_oe", 1'h0, irq_req_oe);
        apb(1'h0, adr(1'h0, dcw_pkg::REG_PEND), 32'h0);
        chk("pend_b_tx", 1'h0, rdat[4]);
        wr(adr(1'h0, dcw_pkg::REG_CMD), 8'h10);
        tx_empty[0] <= 1'h0;
        wr(adr(1'h1, dcw_pkg::REG_MIC), 8'h09);
        tx_written[0] <= 1'h1;
        @(posedge clk);
        tx_written <= 2'h0;
        tx_empty[0] <= 1'h1;
        pend(1, 8'h00);
        pend(1, 8'h02);
        chk("irq_oe", 1'h1, irq_req_oe);
        wr(adr(1'h1, dcw_pkg::REG_MODE), 8'h01);
        for (int k = 0; k < 6; k++)
        begin
            case (k)
                0: cts_n[1] <= 1'h0;
                1: carrier_detect_in_n[1] <= 1'h0;
                2: ring_indicator_in_n[1] <= 1'h0;
                3: tx_underrun[1] <= 1'h1;
                4: baud_zero[1] <= 1'h1;
                default: break_det[1] <= 1'h1;
            endcase
            @(posedge clk);
            {tx_underrun, baud_zero, break_det} <= 6'h00;
            pend(2, 8'h22);
            if (k < 5)
                wr(adr(1'h1, dcw_pkg::REG_CMD), 8'h08);
        end
        rdc(adr(1'h1, dcw_pkg::REG_VEC), 8'hF8);
        chain_enable_in <= 1'h0;
        repeat (8) @(posedge clk);
        chk("irq_oe", 1'h0, irq_req_oe);
        chain_enable_in <= 1'h1;
        repeat (8) @(posedge clk);
        host.ack_go();
        chk("ad_oe", 1'h1, ad_oe);
        chk("ad_o", 8'hF8, ad_o);
        host.ack_done();
        wr(adr(1'h0, dcw_pkg::REG_CMD), 8'h10);
        repeat (6) @(posedge clk);
        chk("irq_oe", 1'h0, irq_req_oe);
        wr(adr(1'h0, dcw_pkg::REG_CMD), 8'h20);
        repeat (6) @(posedge clk);
        chk("irq_oe", 1'h1, irq_req_oe);
        host.ack_go();
        chk("ad_o", 8'hF2, ad_o);
        host.ack_done();
        wr(adr(1'h1, dcw_pkg::REG_CMD), 8'h08);
        wr(adr(1'h1, dcw_pkg::REG_CMD), 8'h20);
        repeat (6) @(posedge clk);
        chk("chain_out", 1'h1, chain_enable_out);
        rxs(8'h10, 1'h0, 8'h01);
        rxs(8'h18, 1'h0, 8'h00);
        rxs(8'h00, 1'h1, 8'h01);
        rxs(8'h08, 1'h0, 8'h01);
        rxs(8'h00, 1'h0, 8'h00);
        rxs(8'h00, 1'h1, 8'h01);
        wr(adr(1'h1, dcw_pkg::REG_CMD), 8'h28);
        shl = 1'h1;
        rdc(adr(1'h0, dcw_pkg::REG_VEC), 8'hF0);
        rdc(adr(1'h1, dcw_pkg::REG_VEC), 8'hF6);
        wr(adr(1'h1, dcw_pkg::REG_CMD), 8'h30);
        shl = 1'h0;
        wr(adr(1'h0, dcw_pkg::REG_MODE), 8'hC0);
        repeat (4) @(posedge clk);
        chk("wreq_oe", 1'h1, wreq_oe[0]);
        chk("wreq_n", 1'h0, wreq_n_o[0]);
        tx_empty[0] <= 1'h0;
        repeat (4) @(posedge clk);
        chk("wreq_n", 1'h1, wreq_n_o[0]);
        wr(adr(1'h0, dcw_pkg::REG_MODE), 8'h80);
        repeat (4) @(posedge clk);
        fork
            wr(adr(1'h0, dcw_pkg::REG_DATA), 8'h00);
            begin
                repeat (4) @(posedge clk);
                chk("wait_oe", 1'h1, wreq_oe[0]);
                tx_empty[0] <= 1'h1;
            end
        join
        chk("wait_oe", 1'h0, wreq_oe[0]);
        wr(adr(1'h0, dcw_pkg::REG_MISC), 8'h04);
        repeat (4) @(posedge clk);
        chk("dtr", 1'h0, dtr_req_n[0]);
        final_report();
    end
endmodule : testbench
